// >>> rtl/ssar_pkg.sv
// constants for the serial-link status and advertisement register bank
// Behaviour
// - set complete after acknowledge codewords exchanged
// - serdes only: latch partner link-down fault high
// - link status latched low until status read
// - two read-only identifier words, consecutive offsets
// - serdes transmit codeword built from advertisement
// - control changes apply on advertisement write
// - next-page advertisement bit always reads zero
// - bits 13:12 carry local fault code
// - bits 8:7 advertise local pause ability
// - half duplex default 0, full default 1
// - negotiation runs only while enable set
package ssar_pkg;
  localparam int ADDR_W = 23;
  localparam int IDX_W  = 21;

  // printed offsets are word indices; byte address is four times these
  localparam logic [IDX_W-1:0] IDX_STATUS   = 21'h1f0001;
  localparam logic [IDX_W-1:0] IDX_ID_HI    = 21'h1f0002;
  localparam logic [IDX_W-1:0] IDX_ID_LO    = 21'h1f0003;
  localparam logic [IDX_W-1:0] IDX_ADV      = 21'h1f0004;
  localparam logic [IDX_W-1:0] IDX_CTRL     = 21'h1f0010;
  localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 21'h1f0011;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 21'h1f0012;

  // status word
  localparam int ST_COMPLETE = 5;
  localparam int ST_RFAULT   = 4;
  localparam int ST_LINK     = 2;
  localparam logic [15:0] ST_FIXED = 16'h0189;

  // advertisement word
  localparam int ADV_NP        = 15;
  localparam int ADV_RF_LSB    = 12;
  localparam int ADV_PAUSE_LSB = 7;
  localparam int ADV_HD        = 6;
  localparam int ADV_FD        = 5;
  localparam logic [15:0] ADV_WMASK = 16'h31e0;
  localparam logic [15:0] ADV_RESET = 16'h0020;
  localparam logic [1:0]  RF_LINK_FAIL = 2'h2;

  // control word, same bit places as the negotiation control register
  localparam int CTRL_AN_EN   = 12;
  localparam int CTRL_RESTART = 9;
  localparam logic CTRL_AN_EN_RST = 1'h1;

  // sgmii side sends a fixed base word
  localparam logic [15:0] SGMII_TX_WORD = 16'h0001;

  // interrupt bits
  localparam int IRQ_W        = 3;
  localparam int IRQ_COMPLETE = 0;
  localparam int IRQ_RFAULT   = 1;
  localparam int IRQ_LINKDN   = 2;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : ssar_pkg

// >>> rtl/ssar_reg_if.sv
// register access strobes between the bus slave and the register bank
interface ssar_reg_if;
  import ssar_pkg::*;
  logic             wr_req;
  logic [IDX_W-1:0] wr_idx;
  logic [31:0]      wdata;
  logic [3:0]       wstrb;
  logic             wr_err;
  logic             rd_req;
  logic [IDX_W-1:0] rd_idx;
  logic [15:0]      rdata;
  logic             rd_err;
  modport bus  (output wr_req, wr_idx, wdata, wstrb, rd_req, rd_idx,
                input  wr_err, rdata, rd_err);
  modport regs (input  wr_req, wr_idx, wdata, wstrb, rd_req, rd_idx,
                output wr_err, rdata, rd_err);
endinterface : ssar_reg_if

// >>> rtl/ssar_axil_slave.sv
// axi4-lite slave turning bus beats into register strobes
module ssar_axil_slave import ssar_pkg::*; (
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // write channels
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // read channels
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // register side
  ssar_reg_if.bus                rif
);
  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              arready;
    logic              aw_have;
    logic              w_have;
    logic [ADDR_W-1:0] awaddr;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } ssar_axil_s;

  ssar_axil_s q;
  ssar_axil_s d;

  assign rif.wr_req = q.aw_have && q.w_have;
  assign rif.wr_idx = q.awaddr[ADDR_W-1:2];
  assign rif.wdata  = q.wdata;
  assign rif.wstrb  = q.wstrb;
  // read strobe fires in the address beat so side effects happen once
  assign rif.rd_req = arvalid && q.arready;
  assign rif.rd_idx = araddr[ADDR_W-1:2];

  always_comb begin
    d = q;
    if (awvalid && q.awready) begin
      d.awready = 1'b0;
      d.aw_have = 1'b1;
      d.awaddr  = awaddr;
    end
    if (wvalid && q.wready) begin
      d.wready = 1'b0;
      d.w_have = 1'b1;
      d.wdata  = wdata;
      d.wstrb  = wstrb;
    end
    if (q.aw_have && q.w_have) begin
      d.aw_have = 1'b0;
      d.w_have  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = rif.wr_err ? RESP_SLVERR : RESP_OKAY;
    end
    if (q.bvalid && bready) begin
      d.bvalid  = 1'b0;
      d.awready = 1'b1;
      d.wready  = 1'b1;
    end
    if (arvalid && q.arready) begin
      d.arready = 1'b0;
      d.rvalid  = 1'b1;
      d.rdata   = {16'h0000, rif.rdata};
      d.rresp   = rif.rd_err ? RESP_SLVERR : RESP_OKAY;
    end
    if (q.rvalid && rready) begin
      d.rvalid  = 1'b0;
      d.arready = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q         <= '0;
      q.awready <= 1'b1;
      q.wready  <= 1'b1;
      q.arready <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign awready = q.awready;
  assign wready  = q.wready;
  assign arready = q.arready;
  assign bvalid  = q.bvalid;
  assign bresp   = q.bresp;
  assign rvalid  = q.rvalid;
  assign rdata   = q.rdata;
  assign rresp   = q.rresp;
endmodule : ssar_axil_slave

// >>> rtl/ssar_an_engine.sv
// negotiation progress tracker and partner word holder
module ssar_an_engine import ssar_pkg::*; (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // control
  input  wire logic        an_en,
  input  wire logic        restart,
  // pcs side
  input  wire logic        link_up,
  input  wire logic        ack_done,
  input  wire logic [15:0] partner_word,
  // results
  output logic             complete,
  output logic [15:0]      lp_word
);
  typedef enum logic [1:0] {AN_IDLE, AN_NEG, AN_DONE} ssar_an_e;
  typedef struct packed {
    ssar_an_e    state;
    logic        complete;
    logic [15:0] lp_word;
  } ssar_an_s;

  ssar_an_s q;
  ssar_an_s d;

  always_comb begin
    d = q;
    case (q.state)
      AN_IDLE: begin
        d.state = AN_NEG;
      end
      AN_NEG: begin
        if (ack_done) begin
          d.state   = AN_DONE;
          d.lp_word = partner_word;
        end
      end
      AN_DONE: begin
        d.lp_word = q.lp_word;
      end
      default: begin
        d.state = AN_IDLE;
      end
    endcase
    // disabled or no link holds idle
    if (!an_en || !link_up) begin
      d.state = AN_IDLE;
    end else if (restart) begin
      d.state = AN_NEG;
    end
    d.complete = (d.state == AN_DONE);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q       <= '0;
      q.state <= AN_IDLE;
    end else begin
      q <= d;
    end
  end

  assign complete = q.complete;
  assign lp_word  = q.lp_word;

  en_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !an_en |=> !complete)
    else $error("negotiation complete while disabled");
  ack_done_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.state == AN_NEG && ack_done && an_en && link_up && !restart)
      |=> complete && lp_word == $past(partner_word))
    else $error("acknowledge exchange did not complete negotiation");
  lp_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    complete ##1 complete |-> $stable(lp_word))
    else $error("partner word changed while complete");
endmodule : ssar_an_engine

// >>> rtl/ssar_regs.sv
// status, identifier and advertisement register bank with axi4-lite access
//
// The AXI4-Lite interface to the registers was decided locally.
module ssar_regs import ssar_pkg::*; #(
  // arbitrary identifier values
  parameter logic [15:0] ID_HI = 16'h1234,
  parameter logic [15:0] ID_LO = 16'h5678
) (
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite write
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // axi4-lite read
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // pcs side
  input  wire logic              sgmii_mode,
  input  wire logic              rx_link_up,
  input  wire logic              ack_done,
  input  wire logic [15:0]       partner_word,
  output logic [15:0]            tx_config_word,
  output logic                   an_enable,
  output logic                   an_restart,
  output logic                   an_complete,
  output logic [15:0]            lp_word,
  // interrupt
  output logic                   irq
);
  typedef struct packed {
    logic [15:0]      adv;
    logic             pend_en;
    logic             pend_rst;
    logic             an_en;
    logic             restart;
    logic             rfault;
    logic             link_ll;
    logic             prev_cmp;
    logic             prev_up;
    logic             prev_flt;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic             irq;
    logic [15:0]      tx_word;
  } ssar_regs_s;

  ssar_regs_s s_q;
  ssar_regs_s s_d;

  ssar_reg_if rif ();

  logic             an_cmp;
  logic [15:0]      lp_w;
  logic             live_flt;
  logic             rd_status;
  logic             wr_adv;
  logic             wr_ctrl;
  logic             irq_pend;
  logic [IRQ_W-1:0] ev;

  ssar_axil_slave u_axil (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .rif     (rif.bus)
  );

  ssar_an_engine u_an (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .an_en        (s_q.an_en),
    .restart      (s_q.restart),
    .link_up      (rx_link_up),
    .ack_done     (ack_done),
    .partner_word (partner_word),
    .complete     (an_cmp),
    .lp_word      (lp_w)
  );

  function automatic logic reg_known(input logic [IDX_W-1:0] idx);
    reg_known = (idx == IDX_STATUS) || (idx == IDX_ID_HI) ||
                (idx == IDX_ID_LO) || (idx == IDX_ADV) ||
                (idx == IDX_CTRL) || (idx == IDX_IRQ_STAT) ||
                (idx == IDX_IRQ_MASK);
  endfunction : reg_known

  // byte lanes above bit 15 carry nothing
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [15:0] nw,
                                          input logic [1:0]  strb);
    merge16 = old;
    if (strb[0]) begin
      merge16[7:0] = nw[7:0];
    end
    if (strb[1]) begin
      merge16[15:8] = nw[15:8];
    end
  endfunction : merge16

  assign rif.wr_err = !reg_known(rif.wr_idx);
  assign rif.rd_err = !reg_known(rif.rd_idx);
  assign rd_status  = rif.rd_req && (rif.rd_idx == IDX_STATUS);
  assign wr_adv     = rif.wr_req && (rif.wr_idx == IDX_ADV);
  assign wr_ctrl    = rif.wr_req && (rif.wr_idx == IDX_CTRL);
  assign irq_pend   = |(s_q.irq_stat & s_q.irq_mask);

  // partner reports its receive link failed, serdes only
  assign live_flt = an_cmp && !sgmii_mode &&
                    (lp_w[ADV_RF_LSB+1:ADV_RF_LSB] == RF_LINK_FAIL);

  always_comb begin
    ev               = '0;
    ev[IRQ_COMPLETE] = an_cmp && !s_q.prev_cmp;
    ev[IRQ_RFAULT]   = live_flt && !s_q.prev_flt;
    ev[IRQ_LINKDN]   = s_q.prev_up && !rx_link_up;
  end

  // read mux shows the old latched values; clearing follows the read
  always_comb begin
    rif.rdata = 16'h0000;
    if (rif.rd_idx == IDX_STATUS) begin
      rif.rdata              = ST_FIXED;
      rif.rdata[ST_COMPLETE] = an_cmp;
      rif.rdata[ST_RFAULT]   = s_q.rfault;
      rif.rdata[ST_LINK]     = s_q.link_ll;
    end else if (rif.rd_idx == IDX_ID_HI) begin
      rif.rdata = ID_HI;
    end else if (rif.rd_idx == IDX_ID_LO) begin
      rif.rdata = ID_LO;
    end else if (rif.rd_idx == IDX_ADV) begin
      rif.rdata = s_q.adv;
    end else if (rif.rd_idx == IDX_CTRL) begin
      rif.rdata[CTRL_AN_EN]   = s_q.pend_en;
      rif.rdata[CTRL_RESTART] = s_q.pend_rst;
    end else if (rif.rd_idx == IDX_IRQ_STAT) begin
      rif.rdata[IRQ_W-1:0] = s_q.irq_stat;
    end else if (rif.rd_idx == IDX_IRQ_MASK) begin
      rif.rdata[IRQ_W-1:0] = s_q.irq_mask;
    end
  end

  always_comb begin
    s_d          = s_q;
    s_d.restart  = 1'b0;
    s_d.prev_cmp = an_cmp;
    s_d.prev_up  = rx_link_up;
    s_d.prev_flt = live_flt;

    // latched high, a fresh fault beats the clearing read
    // after the clearing read the bit follows the live fault
    s_d.rfault  = live_flt || (s_q.rfault && !rd_status);
    // latched low; a drop in the read cycle still wins
    // read re-arms the bit from the live link
    s_d.link_ll = rx_link_up && (s_q.link_ll || rd_status);

    if (wr_adv) begin
      // next page never stored, reads zero
      // only fault, pause and duplex fields writable
      s_d.adv = merge16(s_q.adv, rif.wdata[15:0], rif.wstrb[1:0])
                & ADV_WMASK;
      // pending control takes effect on this write
      s_d.an_en    = s_q.pend_en;
      s_d.restart  = s_q.pend_rst;
      s_d.pend_rst = 1'b0;
    end
    if (wr_ctrl) begin
      if (rif.wstrb[1]) begin
        s_d.pend_en = rif.wdata[CTRL_AN_EN];
      end
      s_d.pend_rst = s_q.pend_rst ||
                     (rif.wstrb[1] && rif.wdata[CTRL_RESTART]);
    end

    // sticky events, set wins over write-one-to-clear
    s_d.irq_stat = s_q.irq_stat;
    if (rif.wr_req && rif.wr_idx == IDX_IRQ_STAT && rif.wstrb[0]) begin
      s_d.irq_stat = s_q.irq_stat & ~rif.wdata[IRQ_W-1:0];
    end
    s_d.irq_stat = s_d.irq_stat | ev;
    if (rif.wr_req && rif.wr_idx == IDX_IRQ_MASK && rif.wstrb[0]) begin
      s_d.irq_mask = rif.wdata[IRQ_W-1:0];
    end
    s_d.irq = irq_pend;

    // serdes base page is the advertisement word
    s_d.tx_word = sgmii_mode ? SGMII_TX_WORD : s_q.adv;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q         <= '0;
      s_q.adv     <= ADV_RESET;
      s_q.pend_en <= CTRL_AN_EN_RST;
      s_q.an_en   <= CTRL_AN_EN_RST;
      s_q.tx_word <= ADV_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign tx_config_word = s_q.tx_word;
  assign an_enable      = s_q.an_en;
  assign an_restart     = s_q.restart;
  assign an_complete    = an_cmp;
  assign lp_word        = lp_w;
  assign irq            = s_q.irq;

  np_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (rif.rd_req && rif.rd_idx == IDX_ADV) |-> !rif.rdata[ADV_NP])
    else $error("next page bit read as one");
  link_drop_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !rx_link_up |=> !s_q.link_ll)
    else $error("link status not cleared on link loss");
  link_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!s_q.link_ll && !rd_status) |=> !s_q.link_ll)
    else $error("latched low link status released without read");
  link_rearm_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (rd_status && rx_link_up) ##1 rx_link_up |-> s_q.link_ll)
    else $error("link status not re-armed after read");
  rfault_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    live_flt |=> s_q.rfault ##1 (s_q.rfault || $past(rd_status)))
    else $error("remote fault not latched");
  rfault_mode_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(s_q.rfault) |-> !$past(sgmii_mode))
    else $error("remote fault set in sgmii mode");
  ctrl_wait_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_ctrl && !wr_adv) |=> $stable(s_q.an_en))
    else $error("control change applied before advertisement write");
  ctrl_commit_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_adv |=> (s_q.an_en == $past(s_q.pend_en)))
    else $error("advertisement write did not commit control");
  adv_field_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_adv && rif.wstrb[1]) |=> (s_q.adv[13:12] == $past(rif.wdata[13:12])))
    else $error("fault code not stored");
  tx_word_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !sgmii_mode |=> (tx_config_word == $past(s_q.adv)))
    else $error("transmit word differs from advertisement");
  irq_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
    irq_pend |=> irq)
    else $error("interrupt missing for unmasked event");
  irq_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !irq_pend |=> !irq)
    else $error("interrupt without unmasked event");
  ev_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (|ev) |=> ((s_q.irq_stat & $past(ev)) == $past(ev)))
    else $error("event lost against a clearing write");
  id_words_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (rif.rd_req && rif.rd_idx == IDX_ID_LO) |=> (rdata[15:0] == ID_LO))
    else $error("identifier word not returned");
  pause_adv_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_adv && rif.wstrb[0] && rif.wstrb[1]) |=>
      (s_q.adv[ADV_PAUSE_LSB+:2] == $past(rif.wdata[ADV_PAUSE_LSB+:2])))
    else $error("pause field not stored");
  dup_adv_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_adv && rif.wstrb[0]) |=>
      (s_q.adv[ADV_HD:ADV_FD] == $past(rif.wdata[ADV_HD:ADV_FD])))
    else $error("duplex bits not stored");
  cmp_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_status |=> (rdata[ST_COMPLETE] == $past(an_cmp)))
    else $error("status read missed completion flag");
  link_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_status |=> (rdata[ST_LINK] == $past(s_q.link_ll)))
    else $error("status read missed latched link bit");
  rst_pulse_a: assert property (@(posedge aclk) disable iff (!aresetn)
    an_restart |=> !an_restart)
    else $error("restart held longer than one cycle");
endmodule : ssar_regs

// >>> tb/ssar_link_partner.sv
// remote link partner model: link level and one acknowledged base page
module ssar_link_partner import ssar_pkg::*; (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // scenario controls
  input  wire logic        link_req,
  input  wire logic [1:0]  fault_code,
  input  wire logic [3:0]  ack_wait,
  // local device side
  input  wire logic        an_enable,
  input  wire logic        an_restart,
  input  wire logic [15:0] tx_config_word,
  output logic             rx_link_up,
  output logic             ack_done,
  output logic [15:0]      partner_word
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0]  cnt;
  logic        sent;
  logic [15:0] page;
  // ack bit set, fault code, full duplex only
  assign page = {2'b01, fault_code, 12'h020};
  always @(posedge aclk) begin
    rx_link_up <= aresetn && link_req;
    ack_done <= 1'b0;
    // word inverts every cycle outside the acknowledge cycle
    partner_word <= aresetn ? ~partner_word : 16'h0000;
    if (!aresetn || !rx_link_up || !an_enable || an_restart) begin
      cnt <= 4'h0;
      sent <= 1'b0;
    end else if (!sent && tx_config_word != 16'h0000) begin
      if (cnt == ack_wait) begin
        ack_done <= 1'b1;
        partner_word <= page;
        sent <= 1'b1;
      end else begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule : ssar_link_partner

// >>> tb/sgmii_status_advert_regs_tb.sv
// self-checking bench for the status and advertisement register bank
`define CHK(nm, exp, got) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
      fails++; \
      $display("[FAIL] %s expected %h seen %h", nm, exp, got); \
    end \
  end

module sgmii_status_advert_regs_tb import ssar_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic              aclk, aresetn, link_req;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic              awvalid, awready, wvalid, wready, bvalid, bready;
  logic [31:0]       wdata, rdata;
  logic [3:0]        wstrb, ack_wait;
  logic [1:0]        bresp, rresp, fault_code, rr;
  logic              arvalid, arready, rvalid, rready;
  logic              sgmii_mode, rx_link_up, ack_done;
  logic [15:0]       partner_word, tx_config_word, lp_word, rd_q, wd;
  logic              an_enable, an_restart, an_complete, irq;
  int                fails, total_checks, restarts, r0;

  ssar_regs dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .sgmii_mode(sgmii_mode), .rx_link_up(rx_link_up),
    .ack_done(ack_done), .partner_word(partner_word),
    .tx_config_word(tx_config_word), .an_enable(an_enable),
    .an_restart(an_restart), .an_complete(an_complete),
    .lp_word(lp_word), .irq(irq));

  ssar_link_partner partner (.aclk(aclk), .aresetn(aresetn),
    .link_req(link_req), .fault_code(fault_code), .ack_wait(ack_wait),
    .an_enable(an_enable), .an_restart(an_restart),
    .tx_config_word(tx_config_word), .rx_link_up(rx_link_up),
    .ack_done(ack_done), .partner_word(partner_word));

  always #25 aclk = ~aclk;
  always @(posedge aclk) begin
    if (an_restart === 1'b1) restarts++;
  end

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish

  // callers enter just after a rising edge
  task automatic wr(input logic [IDX_W-1:0] idx, input logic [15:0] d,
                    input logic [1:0] exp_resp);
    logic [1:0] resp;
    resp = 2'h3;
    awaddr <= {idx, 2'b00};
    wdata <= {16'h0000, d};
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
    // one spare edge so the next call never reassigns in this step
    @(posedge aclk);
    `CHK("write response", exp_resp, resp)
  endtask : wr

  task automatic rd(input logic [IDX_W-1:0] idx, output logic [15:0] d,
                    output logic [1:0] resp);
    d = 16'hxxxx;
    resp = 2'h3;
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata[15:0];
    resp = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask : rd

  task automatic rd_chk(input logic [IDX_W-1:0] idx,
                        input logic [15:0] exp, input string nm);
    logic [15:0] d;
    logic [1:0]  r;
    rd(idx, d, r);
    `CHK(nm, exp, d)
    `CHK("read response", RESP_OKAY, r)
  endtask : rd_chk

  task automatic wait_complete(input logic exp);
    for (int n = 0; n < 60; n++) begin
      @(posedge aclk);
      if (an_complete === exp) break;
    end
    `CHK("complete", exp, an_complete)
  endtask : wait_complete

  // tests need about 200 cycles; this is far beyond
  initial begin
    #1000000;
    fails++;
    tally_and_finish();
  end

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = '0;
    araddr = '0;
    wdata = 32'h0;
    wstrb = 4'h0;
    sgmii_mode = 1'b0;
    link_req = 1'b0;
    fault_code = 2'h0;
    ack_wait = 4'h2;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    `CHK("enable", 1'b1, an_enable)
    `CHK("tx word", ADV_RESET, tx_config_word)
    rd_chk(IDX_STATUS, 16'h0189, "status");
    rd_chk(IDX_ID_HI, 16'h1234, "id high");
    rd_chk(IDX_ID_LO, 16'h5678, "id low");
    rd_chk(IDX_ADV, 16'h0020, "adv");
    wr(IDX_ID_HI, 16'hffff, RESP_OKAY);
    rd_chk(IDX_ID_HI, 16'h1234, "id high");
    wr(21'h1f0005, 16'hffff, RESP_SLVERR);
    rd(21'h1f0005, rd_q, rr);
    `CHK("unmapped resp", RESP_SLVERR, rr)
    `CHK("unmapped data", 16'h0000, rd_q)
    wr(IDX_ADV, 16'hffff, RESP_OKAY);
    rd_chk(IDX_ADV, 16'h31e0, "adv");
    for (int i = 0; i < 4; i++) begin
      wd = (16'(i) << 12) | (16'(3 - i) << 7) | (16'(i & 1) << 6);
      wd = wd | (16'(i >> 1) << 5);
      wr(IDX_ADV, wd, RESP_OKAY);
      rd_chk(IDX_ADV, wd, "adv fields");
      `CHK("tx word", wd, tx_config_word)
    end
    $display("test registers done");

    link_req <= 1'b1;
    wait_complete(1'b1);
    `CHK("partner word", 16'h4020, lp_word)
    rd_chk(IDX_STATUS, 16'h01a9, "status");
    rd_chk(IDX_STATUS, 16'h01ad, "status");
    `CHK("irq masked", 1'b0, irq)
    rd_chk(IDX_IRQ_STAT, 16'h0001, "irq status");
    wr(IDX_IRQ_MASK, 16'h0007, RESP_OKAY);
    repeat (2) @(posedge aclk);
    `CHK("irq", 1'b1, irq)
    wr(IDX_IRQ_STAT, 16'h0007, RESP_OKAY);
    repeat (2) @(posedge aclk);
    `CHK("irq cleared", 1'b0, irq)
    rd_chk(IDX_IRQ_STAT, 16'h0000, "irq status");
    $display("test negotiation done");

    link_req <= 1'b0;
    repeat (4) @(posedge aclk);
    `CHK("complete on loss", 1'b0, an_complete)
    link_req <= 1'b1;
    wait_complete(1'b1);
    rd_chk(IDX_STATUS, 16'h01a9, "status");
    rd_chk(IDX_STATUS, 16'h01ad, "status");
    rd_chk(IDX_IRQ_STAT, 16'h0005, "irq status");
    wr(IDX_IRQ_STAT, 16'h0007, RESP_OKAY);
    $display("test link loss done");

    link_req <= 1'b0;
    fault_code <= RF_LINK_FAIL;
    repeat (4) @(posedge aclk);
    link_req <= 1'b1;
    wait_complete(1'b1);
    `CHK("partner word", 16'h6020, lp_word)
    rd_chk(IDX_STATUS, 16'h01b9, "status");
    rd_chk(IDX_STATUS, 16'h01bd, "status");
    sgmii_mode <= 1'b1;
    repeat (3) @(posedge aclk);
    `CHK("sgmii tx word", SGMII_TX_WORD, tx_config_word)
    rd_chk(IDX_STATUS, 16'h01bd, "status");
    rd_chk(IDX_STATUS, 16'h01ad, "status");
    $display("test remote fault done");

    wr(IDX_CTRL, 16'h0000, RESP_OKAY);
    `CHK("enable pending", 1'b1, an_enable)
    rd_chk(IDX_CTRL, 16'h0000, "ctrl");
    wr(IDX_ADV, 16'h0020, RESP_OKAY);
    `CHK("enable", 1'b0, an_enable)
    wait_complete(1'b0);
    ack_wait <= 4'h9;
    wr(IDX_CTRL, 16'h1200, RESP_OKAY);
    rd_chk(IDX_CTRL, 16'h1200, "ctrl");
    r0 = restarts;
    wr(IDX_ADV, 16'h0020, RESP_OKAY);
    `CHK("enable", 1'b1, an_enable)
    `CHK("restart pulses", r0 + 1, restarts)
    wait_complete(1'b1);
    rd_chk(IDX_CTRL, 16'h1000, "ctrl");
    $display("test commit done");
    tally_and_finish();
  end
endmodule : sgmii_status_advert_regs_tb
